//--- core/irq_rst_defs.vh
`ifndef IRQ_RST_DEFS_VH
`define IRQ_RST_DEFS_VH
// ==========================================================
// Register offsets (byte addresses)
`define OFF_FLAG 12'h000
`define OFF_MASK 12'h004
`define OFF_STATUS 12'h008
`define OFF_CTRL 12'h00C
// ==========================================================
// Field positions
`define BIT_TIMER 0
`define BIT_CHANGE 1
`define BIT_EXT 2
`define ST_HALTED 0
`define ST_WDOG 1
`define ST_EDGE 2
`define ST_GIE 3
`define ST_SLEEP 4
// ==========================================================
// Vectors and reset values
`define VEC_IRQ 11'h008
`define VEC_SWI 11'h001
`define FLAG_RST 3'h0
`define MASK_RST 3'h0
`define DIR_RST 8'hFF
`endif

//--- core/irq_and_reset_status.v
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Power-on, reset-pin pulse, or watchdog expiry each start a reset.
// - Power-on: edge flag 0, watchdog flag 1, halted marker 1.
// - Reset pin while running: edge flag 0, other two kept.
// - Reset pin waking sleep: edge 0, watchdog 1, halted 0.
// - Watchdog expiry while running: edge 0, watchdog 0, halted kept.
// - Watchdog expiry waking sleep: all three cleared.
// - Pin-change wake: edge 1, watchdog 1, halted 0.
// - Watchdog-clear sets watchdog and halted; sleep sets watchdog, clears halted.
// - Three falling-edge sources: timer overflow, port change, external pin; the timer is taken on its rising edge here, the port on any change.
// - Only input pins change-detect; bit 0 excluded when used as interrupt.
// - Enabled change interrupt wakes the core from sleep.
// - After wake, continue in-line if disabled, else vector 008H.
// - Enable instruction sets global enable, disable instruction clears it.
// - Enabled interrupt fetches next instruction from 008H.
// - Flags other than change flag set regardless of mask or enable.
// - Effective request is flag AND mask.
// - Return-from-interrupt sets global enable like the enable instruction.
// - Software interrupt fetches from 001H.
// - Status flags readable in the processor status register.
`include "irq_rst_defs.vh"
module irq_and_reset_status (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire reset_pin_n,
  input wire watchdog_timer_expire,
  input wire free_running_timer_ovf,
  input wire [7:0] port6_pins,
  input wire [7:0] port6_dir,
  input wire port6_bit0_is_int,
  input wire port6_read,
  input wire global_irq_enable_instr,
  input wire global_irq_disable_instr,
  input wire return_from_irq_instr,
  input wire watchdog_clear_instr,
  input wire sleep_instr,
  input wire swi_instr,
  output reg vector_valid,
  output reg [10:0] vector_addr,
  output wire core_reset,
  output wire sleeping,
  output wire [2:0] irq_pending
);
// ==========================================================
// Pin synchronisers (two flops before any logic)
reg [7:0] p6_s1_r;
reg [7:0] p6_s2_r;
reg rst_s1_r;
reg rst_s2_r;
reg rst_s3_r;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    p6_s1_r <= `DIR_RST;
    p6_s2_r <= `DIR_RST;
    rst_s1_r <= 1'b1;
    rst_s2_r <= 1'b1;
    rst_s3_r <= 1'b1;
  end else begin
    p6_s1_r <= port6_pins;
    p6_s2_r <= p6_s1_r;
    rst_s1_r <= reset_pin_n;
    rst_s2_r <= rst_s1_r;
    rst_s3_r <= rst_s2_r;
  end
end
// ==========================================================
// Event detection
reg [7:0] p6_ref_r;
reg ext_prev_r;
reg tmr_prev_r;
wire [7:0] chg_en = port6_dir & ~{7'h00, port6_bit0_is_int};
wire change_evt = |((p6_s2_r ^ p6_ref_r) & chg_en);
wire ext_fall = port6_bit0_is_int & ext_prev_r & ~p6_s2_r[0];
wire tmr_evt = free_running_timer_ovf & ~tmr_prev_r;
wire pin_pulse = rst_s2_r & ~rst_s3_r;
// ==========================================================
// Flags, mask, status
reg [2:0] flag_r;
reg [2:0] mask_r;
reg halted_r;
reg wdog_r;
reg edge_r;
reg gie_r;
reg sleep_r;
reg reset_pulse_r;
wire wr = psel & penable & pwrite;
wire rd_ok = (paddr == `OFF_FLAG) | (paddr == `OFF_MASK) | (paddr == `OFF_STATUS) | (paddr == `OFF_CTRL);
wire [2:0] pend = flag_r & mask_r;
wire change_wake = sleep_r & change_evt & mask_r[`BIT_CHANGE];
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    p6_ref_r <= `DIR_RST;
    ext_prev_r <= 1'b1;
    tmr_prev_r <= 1'b0;
    flag_r <= `FLAG_RST;
    mask_r <= `MASK_RST;
    halted_r <= 1'b1;
    wdog_r <= 1'b1;
    edge_r <= 1'b0;
    gie_r <= 1'b0;
    sleep_r <= 1'b0;
    reset_pulse_r <= 1'b0;
    vector_valid <= 1'b0;
    vector_addr <= 11'h000;
  end else begin
    ext_prev_r <= p6_s2_r[0];
    tmr_prev_r <= free_running_timer_ovf;
    vector_valid <= 1'b0;
    reset_pulse_r <= 1'b0;
    if (port6_read)
      p6_ref_r <= p6_s2_r;
    if (pin_pulse) begin
      reset_pulse_r <= 1'b1;
      edge_r <= 1'b0;
      flag_r <= `FLAG_RST;
      mask_r <= `MASK_RST;
      gie_r <= 1'b0;
      sleep_r <= 1'b0;
      if (sleep_r) begin
        wdog_r <= 1'b1;
        halted_r <= 1'b0;
      end // keeps both otherwise
    end else if (watchdog_timer_expire) begin
      reset_pulse_r <= 1'b1;
      edge_r <= 1'b0;
      wdog_r <= 1'b0;
      flag_r <= `FLAG_RST;
      mask_r <= `MASK_RST;
      gie_r <= 1'b0;
      sleep_r <= 1'b0;
      if (sleep_r)
        halted_r <= 1'b0;
    end else begin
      // Set beats clear so an event in the clear cycle is kept
      if (wr && paddr == `OFF_FLAG)
        flag_r <= pwdata[2:0] & flag_r | {ext_fall, change_evt & mask_r[`BIT_CHANGE], tmr_evt};
      else
        flag_r <= flag_r | {ext_fall, change_evt & mask_r[`BIT_CHANGE], tmr_evt};
      if (wr && paddr == `OFF_MASK)
        mask_r <= pwdata[2:0];
      if (change_wake) begin
        edge_r <= 1'b1;
        wdog_r <= 1'b1;
        halted_r <= 1'b0;
        sleep_r <= 1'b0;
        p6_ref_r <= p6_s2_r;
        if (gie_r) begin
          vector_valid <= 1'b1;
          vector_addr <= `VEC_IRQ;
          gie_r <= 1'b0;
        end
      end else if (watchdog_clear_instr) begin
        wdog_r <= 1'b1;
        halted_r <= 1'b1;
      end else if (sleep_instr) begin
        wdog_r <= 1'b1;
        halted_r <= 1'b0;
        sleep_r <= 1'b1;
      end
      if (!change_wake) begin
        if (swi_instr) begin
          vector_valid <= 1'b1;
          vector_addr <= `VEC_SWI;
          gie_r <= 1'b0;
        end else if (gie_r && |pend && !sleep_r) begin
          vector_valid <= 1'b1;
          vector_addr <= `VEC_IRQ;
          gie_r <= 1'b0;
        end else if (global_irq_enable_instr || return_from_irq_instr)
          gie_r <= 1'b1;
        else if (global_irq_disable_instr)
          gie_r <= 1'b0;
      end
    end
  end
end
// ==========================================================
// APB: zero wait states; unmapped addresses error and read zero
assign pready = 1'b1;
assign pslverr = psel & penable & ~rd_ok;
always @* begin
  prdata = 32'h0000_0000;
  case (paddr)
    `OFF_FLAG: prdata = {29'h0000_0000, flag_r};
    `OFF_MASK: prdata = {29'h0000_0000, mask_r};
    `OFF_STATUS: prdata = {27'h000_0000, sleep_r, gie_r, edge_r, wdog_r, halted_r};
    default: prdata = 32'h0000_0000;
  endcase
end
assign core_reset = reset_pulse_r;
assign sleeping = sleep_r;
assign irq_pending = pend;
endmodule // irq_and_reset_status

//--- verif/irq_chk.sv
`timescale 1ns/1ps
// ==========
// Port checks
module irq_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pslverr,
  input wire watchdog_timer_expire,
  input wire sleep_instr,
  input wire swi_instr,
  input wire vector_valid,
  input wire [10:0] vector_addr,
  input wire core_reset,
  input wire sleeping,
  input wire [2:0] irq_pending
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_vec_addr: assert property (vector_valid |-> vector_addr == 11'h008 || vector_addr == 11'h001)
    else $error("bad vector");
  a_swi_vec: assert property (swi_instr && !watchdog_timer_expire && !sleeping |=> vector_valid && vector_addr == 11'h001)
    else $error("no soft vector");
  a_wdog_rst: assert property (watchdog_timer_expire |=> core_reset)
    else $error("no watchdog reset");
  a_rst_pulse: assert property (core_reset |=> !core_reset)
    else $error("reset too long");
  a_sleep_set: assert property (sleep_instr && !watchdog_timer_expire |=> sleeping)
    else $error("no sleep");
  a_wdog_wake: assert property (watchdog_timer_expire && sleeping |=> !sleeping)
    else $error("no wake");
  a_pend_clear: assert property ($rose(presetn) |-> irq_pending == 3'h0)
    else $error("pending after reset");
  // Error only shows in the access phase, never in setup
  a_unmapped: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
    else $error("no slave error");
  cover property (core_reset);
  cover property (vector_valid);
  cover property (sleeping && watchdog_timer_expire);
endmodule // irq_chk

//--- verif/core_seq.sv
`timescale 1ns/1ps
// ==========
// Sequencer and watchdog model
module core_seq (
  input wire pclk,
  input wire [2:0] op,
  output reg [6:0] fire
);
  // One pulse a cycle: the sequencer retires one instruction at a time
  initial fire = 7'h00;
  always @(posedge pclk) begin
    fire <= (op == 3'h0) ? 7'h00 : (7'h01 << (op - 3'h1));
  end
endmodule // core_seq

//--- verif/tb.sv
`timescale 1ns/1ps
`include "irq_rst_defs.vh"
// ==========
// Bench
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic free_running_timer_ovf = 1'b0, reset_pin_n = 1'b1, port6_bit0_is_int = 1'b0, port6_read = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, seed = 32'h3246_09b3, r;
  logic [7:0] port6_pins = 8'h00, port6_dir = 8'h00;
  logic [2:0] opc = 3'h0;
  logic [2:0] ops [8] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h5, 3'h7, 3'h6};
  logic [4:0] exs [8] = '{5'h0b, 5'h03, 5'h0b, 5'h01, 5'h03, 5'h12, 5'h00, 5'h00};
  wire [31:0] prdata;
  wire pready, pslverr, vector_valid, core_reset, sleeping;
  wire [10:0] vector_addr;
  wire [2:0] irq_pending;
  wire [6:0] fire;
  wire global_irq_enable_instr, global_irq_disable_instr, return_from_irq_instr;
  wire watchdog_clear_instr, sleep_instr, swi_instr, watchdog_timer_expire;
  int errors = 0, check_count = 0;
  logic [31:0] exq [$];
  logic [10:0] vq [$];
  assign {watchdog_timer_expire, swi_instr, sleep_instr, watchdog_clear_instr} = fire[6:3];
  assign {return_from_irq_instr, global_irq_disable_instr, global_irq_enable_instr} = fire[2:0];
  irq_and_reset_status DUT (.*);
  core_seq seq_u (.pclk(pclk), .op(opc), .fire(fire));
  always #5 pclk = ~pclk;
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task ap(input w, input [11:0] a, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input [11:0] a, input [31:0] e);
    exq.push_back(e);
    ap(1'b0, a, 32'h0000_0000);
  endtask
  task op(input [2:0] k);
    if (k == 3'h6) vq.push_back(`VEC_SWI);
    opc <= k;
    @(posedge pclk) opc <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask
  // Pin reset ends on the rising edge, then passes the synchroniser
  task pin_rst;
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge pclk);
    reset_pin_n <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  // Read data is only valid at the access edge, so compare there
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk("rdata", prdata, exq.pop_front());
    if (vector_valid === 1'b1) chk("vector", 32'(vector_addr), 32'(vq.pop_front()));
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFF_STATUS, 32'h0000_0003);
    for (int i = 0; i < 8; i++) begin
      op(ops[i]);
      rd(`OFF_STATUS, 32'(exs[i]));
    end
    free_running_timer_ovf <= 1'b1;
    r = $random(seed);
    ap(1'b1, `OFF_MASK, r);
    port6_pins <= r[15:8];
    repeat (4) @(posedge pclk);
    rd(`OFF_FLAG, 32'h0000_0001);
    rd(`OFF_MASK, r & 32'h0000_0007);
    chk("pending", 32'(irq_pending), r & 32'h0000_0001);
    ap(1'b1, `OFF_MASK, 32'h0000_0001);
    vq.push_back(`VEC_IRQ);
    op(3'h1);
    ap(1'b1, `OFF_FLAG, 32'h0000_0000);
    rd(`OFF_FLAG, 32'h0000_0000);
    port6_dir <= 8'h0f;
    port6_read <= 1'b1;
    @(posedge pclk) port6_read <= 1'b0;
    ap(1'b1, `OFF_MASK, 32'h0000_0002);
    op(3'h1);
    op(3'h5);
    vq.push_back(`VEC_IRQ);
    port6_pins <= port6_pins ^ 8'h02;
    repeat (4) @(posedge pclk);
    rd(`OFF_STATUS, 32'h0000_0006);
    rd(`OFF_FLAG, 32'h0000_0002);
    op(3'h4);
    pin_rst;
    rd(`OFF_STATUS, 32'h0000_0003);
    op(3'h5);
    pin_rst;
    rd(`OFF_STATUS, 32'h0000_0002);
    chk("vectors left", vq.size(), 32'h0000_0000);
    rd(12'h010, 32'h0000_0000);
    tally_and_finish;
  end
  initial begin
    #50000;
    errors++;
    tally_and_finish;
  end
endmodule // tb
bind irq_and_reset_status irq_chk chk_u (.*);
